// ---- src/mac_pace_pkg.sv ----
// Constants, field layouts and carrier types for the MAC pacing and pause block.
// Assumes a single 125 MHz MAC clock and a 100 Mb/s medium for bit times.
package mac_pace_pkg;

  // ***************************************************************
  // Timing.
  // ***************************************************************
  localparam int CLK_PERIOD_NS  = 8;     // MAC clock period.
  localparam int SLOT_TIME_NS   = 5120;  // 512 bit times at 100 Mb/s.
  localparam int IPG_TIME_NS    = 960;   // 96 bit times at 100 Mb/s.
  // A slot is a period to keep, so it rounds down; a gap is a least time, so it rounds up.
  localparam int SLOT_CYCLES    = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int IPG_CYCLES     = (IPG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PACE_GAP_MULT  = 4;     // Stretched gap in normal gaps.
  localparam int GAP_W          = 10;    // Holds four gaps.
  localparam int SLOT_W         = 10;    // Holds one slot.

  // ***************************************************************
  // Counter widths, loads and reset values.
  // ***************************************************************
  localparam int          PACE_W          = 5;
  localparam int          PAUSE_W         = 16;
  localparam logic [4:0]  PACE_LOAD       = 5'h1F;
  localparam logic [4:0]  PACE_RST        = 5'h00;
  localparam logic [15:0] RX_PAUSE_LOAD   = 16'hFF00;
  localparam logic [15:0] PAUSE_ADVERTISE = 16'hFFFF;
  localparam logic [15:0] PAUSE_RST       = 16'h0000;
  localparam logic [20:0] FILTER_RST      = 21'h000000;

  // ***************************************************************
  // Register byte offsets on the APB.
  // ***************************************************************
  localparam logic [7:0] OFS_PACE     = 8'h00;
  localparam logic [7:0] OFS_RX_PAUSE = 8'h04;
  localparam logic [7:0] OFS_TX_PAUSE = 8'h08;
  localparam logic [7:0] OFS_FILTER   = 8'h0C;

  // ***************************************************************
  // Filter entry low word field positions.
  // ***************************************************************
  localparam int FLT_VALID_BIT = 20;
  localparam int FLT_SEL_BIT   = 19;
  localparam int FLT_CHAN_LSB  = 16;
  localparam int FLT_B0_LSB    = 8;
  localparam int FLT_B1_LSB    = 0;
  localparam int FLT_W         = 21;

  // Filter entry low word; the packing matches bits 20 down to 0.
  typedef struct packed {
    logic       valid;
    logic       match_or_reject_select;
    logic [2:0] channel;
    logic [7:0] station_byte_zero;
    logic [7:0] station_byte_one;
  } filter_entry_t;

  // Outcome of one transmitted frame, qualified by done.
  typedef struct packed {
    logic done;
    logic collided;
    logic deferred;
  } tx_outcome_t;

  // Filter verdict for one received address.
  typedef struct packed {
    logic       accept;
    logic       reject;
    logic [2:0] channel;
  } filter_hit_t;

endpackage

// ---- src/addr_filter_match.sv ----
// Compares one filter entry against the low two bytes of a received address.
// Assumes the entry and address are stable flip-flop values on one clock.
`timescale 1ns/10ps
module addr_filter_match
  import mac_pace_pkg::*;
#(
  parameter int BYTES = 2
) (
  input  wire filter_entry_t       entry_in,
  input  wire logic [BYTES*8-1:0]  addr_in,
  input  wire logic                addr_valid_in,
  output filter_hit_t              hit_out
);

  // ***************************************************************
  // Per-byte compare.
  // ***************************************************************
  logic [BYTES-1:0]   byte_eq;  // One bit per matching byte.
  logic [BYTES*8-1:0] ref_addr; // Entry bytes in address order.

  assign ref_addr = {entry_in.station_byte_zero, entry_in.station_byte_one};

  genvar g;
  generate
    for (g = 0; g < BYTES; g = g + 1) begin : g_byte
      assign byte_eq[g] = (addr_in[g*8 +: 8] == ref_addr[g*8 +: 8]);
    end
  endgenerate

  // ***************************************************************
  // Verdict.
  // ***************************************************************
  // An invalid entry never produces a verdict of either kind.
  always_comb begin
    hit_out = '0;
    if (addr_valid_in && entry_in.valid && (&byte_eq)) begin
      if (entry_in.match_or_reject_select) begin
        hit_out.accept  = 1'b1;
        hit_out.channel = entry_in.channel;
      end else begin
        // The channel is meaningless for a reject entry, so it stays zero.
        hit_out.reject = 1'b1;
      end
    end
  end

endmodule // addr_filter_match

// ---- src/mac_pace_top.sv ----
// Transmit pacing, pause timers and one address filter entry of a MAC port.
// Assumes framer strobes arrive on MCLK_IN and an APB master drives the bus.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module mac_pace_top
  import mac_pace_pkg::*;
#(
  parameter int SLOT_CYC = SLOT_CYCLES,
  parameter int IPG_CYC  = IPG_CYCLES
) (
  input  wire logic         MCLK_IN,
  input  wire logic         SYS_RST_IN,
  // APB slave.
  input  wire logic         PSEL_IN,
  input  wire logic         PENABLE_IN,
  input  wire logic         PWRITE_IN,
  input  wire logic [7:0]   PADDR_IN,
  input  wire logic [31:0]  PWDATA_IN,
  output logic [31:0]       PRDATA_OUT,
  output logic              PREADY_OUT,
  output logic              PSLVERR_OUT,
  // Framer side.
  input  wire tx_outcome_t  TX_OUTCOME_IN,
  input  wire logic         PAUSE_SENT_IN,
  input  wire logic         RX_PAUSE_SEEN_IN,
  input  wire logic [15:0]  RX_PAUSE_QUANTA_IN,
  input  wire logic         RX_CONGESTED_IN,
  output logic              TX_START_OK_OUT,
  output logic              SEND_PAUSE_OUT,
  output logic [15:0]       PAUSE_TIME_OUT,
  // Receive address filter.
  input  wire logic [15:0]  RX_DA_LOW_IN,
  input  wire logic         RX_DA_VALID_IN,
  output filter_hit_t       RX_FILTER_HIT_OUT
);

  // ***************************************************************
  // Slot tick.
  // ***************************************************************
  logic [SLOT_W-1:0] slot_cnt;      // Cycles left in this slot.
  logic [SLOT_W-1:0] next_slot_cnt; // Next slot count.
  logic              slot_tick;     // High in the last cycle of a slot.

  // Free-running divider; both pause timers share it, so a timer load
  // can land anywhere within a slot and the first step may come early.
  always_comb begin
    slot_tick = (slot_cnt == '0);
    if (slot_tick) begin
      next_slot_cnt = SLOT_W'(SLOT_CYC - 1);
    end else begin
      next_slot_cnt = slot_cnt - 1'b1;
    end
  end

  // Slot divider register.
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      slot_cnt <= '0;
    end else begin
      slot_cnt <= next_slot_cnt;
    end
  end

  // ***************************************************************
  // Pacing count and inter-packet gap.
  // ***************************************************************
  logic [PACE_W-1:0] pacing_count;      // Current pacing value.
  logic [PACE_W-1:0] next_pacing_count; // Next pacing value.
  logic [GAP_W-1:0]  gap_cnt;           // Gap cycles still to wait.
  logic [GAP_W-1:0]  next_gap_cnt;      // Next gap count.
  logic              tx_troubled;       // Frame collided or deferred.

  // The gap length is chosen from the pacing value before this frame's
  // own update, so the last paced frame still gets the long gap.
  always_comb begin
    tx_troubled       = TX_OUTCOME_IN.collided | TX_OUTCOME_IN.deferred;
    next_pacing_count = pacing_count;
    next_gap_cnt      = gap_cnt;
    if (gap_cnt != '0) begin
      next_gap_cnt = gap_cnt - 1'b1;
    end
    if (TX_OUTCOME_IN.done) begin
      if (tx_troubled) begin
        next_pacing_count = PACE_LOAD;
        next_gap_cnt      = GAP_W'(IPG_CYC);
      end else begin
        if (pacing_count != '0) begin
          next_pacing_count = pacing_count - 1'b1;
          next_gap_cnt      = GAP_W'(IPG_CYC * PACE_GAP_MULT);
        end else begin
          // Already at zero: the count holds and the gap is normal.
          next_gap_cnt = GAP_W'(IPG_CYC);
        end
      end
    end
  end

  // Pacing and gap registers.
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      pacing_count <= PACE_RST;
      gap_cnt      <= '0;
    end else begin
      pacing_count <= next_pacing_count;
      gap_cnt      <= next_gap_cnt;
    end
  end

  // ***************************************************************
  // Pause timers.
  // ***************************************************************
  logic [PAUSE_W-1:0] flow_hold_countdown;      // Receive-side timer.
  logic [PAUSE_W-1:0] next_flow_hold_countdown; // Next receive-side value.
  logic [PAUSE_W-1:0] tx_pause_cnt;             // Transmit-side timer.
  logic [PAUSE_W-1:0] next_tx_pause_cnt;        // Next transmit-side value.
  logic               send_pause;               // Pause frame requested.
  logic               next_send_pause;          // Next request level.
  logic               start_ok;                 // New frame may start.
  logic               next_start_ok;            // Next start permission.

  // A pause request stands until the framer reports the frame sent.
  // A send wins over a fresh request in the same cycle, and the reload
  // on sending makes the timer nonzero so no new request follows it.
  always_comb begin
    next_flow_hold_countdown = flow_hold_countdown;
    next_tx_pause_cnt        = tx_pause_cnt;
    next_send_pause          = send_pause;
    if (PAUSE_SENT_IN) begin
      next_flow_hold_countdown = RX_PAUSE_LOAD;
      next_send_pause          = 1'b0;
    end else if (slot_tick && (flow_hold_countdown != '0)) begin
      next_flow_hold_countdown = flow_hold_countdown - 1'b1;
    end else if (RX_CONGESTED_IN && (flow_hold_countdown == '0)) begin
      // Timer expired while still congested: ask for another frame.
      next_send_pause = 1'b1;
    end
    if (RX_PAUSE_SEEN_IN) begin
      next_tx_pause_cnt = RX_PAUSE_QUANTA_IN;
    end else if (slot_tick && (tx_pause_cnt != '0)) begin
      next_tx_pause_cnt = tx_pause_cnt - 1'b1;
    end
    // Taken from next values so the output flop tracks both counters
    // with no extra cycle of lag.
    next_start_ok = (next_gap_cnt == '0) && (next_tx_pause_cnt == '0);
  end

  // Pause timer registers.
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      flow_hold_countdown <= PAUSE_RST;
      tx_pause_cnt        <= PAUSE_RST;
      send_pause          <= 1'b0;
      start_ok            <= 1'b1;
    end else begin
      flow_hold_countdown <= next_flow_hold_countdown;
      tx_pause_cnt        <= next_tx_pause_cnt;
      send_pause          <= next_send_pause;
      start_ok            <= next_start_ok;
    end
  end

  // ***************************************************************
  // APB slave.
  // ***************************************************************
  filter_entry_t filter_entry;      // Filter entry low word.
  filter_entry_t next_filter_entry; // Next filter entry.
  logic          next_pready;       // Next ready.
  logic [31:0]   next_prdata;       // Next read data.
  logic          next_pslverr;      // Next error.
  logic          access;            // Access phase, not yet answered.
  logic          mapped;            // Address hits a register.

  // Every access waits one cycle, then answers with registered data.
  // Writes to the read-only counters complete without error and change nothing.
  always_comb begin
    access            = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
    next_filter_entry = filter_entry;
    next_pready       = access;
    next_prdata       = '0;
    next_pslverr      = 1'b0;
    mapped            = 1'b1;
    unique case (PADDR_IN)
      OFS_PACE: begin
        next_prdata = {27'h0000000, pacing_count};
      end
      OFS_RX_PAUSE: begin
        next_prdata = {16'h0000, flow_hold_countdown};
      end
      OFS_TX_PAUSE: begin
        next_prdata = {16'h0000, tx_pause_cnt};
      end
      OFS_FILTER: begin
        next_prdata = {11'h000, filter_entry};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    if (access) begin
      next_pslverr = ~mapped;
      if (PWRITE_IN) begin
        next_prdata = '0;
        if (PADDR_IN == OFS_FILTER) begin
          next_filter_entry = filter_entry_t'(PWDATA_IN[FLT_W-1:0]);
        end
        // Other mapped offsets are read-only and ignore the write.
      end else if (!mapped) begin
        next_prdata = '0;
      end
    end else begin
      next_prdata = '0;
    end
  end

  // APB registers; the entry stores at the edge that also raises ready.
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      filter_entry <= filter_entry_t'(FILTER_RST);
      PREADY_OUT   <= 1'b0;
      PRDATA_OUT   <= '0;
      PSLVERR_OUT  <= 1'b0;
    end else begin
      filter_entry <= next_filter_entry;
      PREADY_OUT   <= next_pready;
      PRDATA_OUT   <= next_prdata;
      PSLVERR_OUT  <= next_pslverr;
    end
  end

  // ***************************************************************
  // Address filter.
  // ***************************************************************
  filter_hit_t hit; // Combinational verdict.

  // The entry write lands at the same edge as the bus answer, which is
  // harmless: software must not change an entry while receiving.
  addr_filter_match #(
    .BYTES (2)
  ) u_match (
    .entry_in      (filter_entry),
    .addr_in       (RX_DA_LOW_IN),
    .addr_valid_in (RX_DA_VALID_IN),
    .hit_out       (hit)
  );

  // ***************************************************************
  // Output registers.
  // ***************************************************************
  // Outputs are flopped once more so none comes from a gate.
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RX_FILTER_HIT_OUT <= '0;
      TX_START_OK_OUT   <= 1'b1;
      SEND_PAUSE_OUT    <= 1'b0;
      PAUSE_TIME_OUT    <= PAUSE_ADVERTISE;
    end else begin
      RX_FILTER_HIT_OUT <= hit;
      TX_START_OK_OUT   <= start_ok;
      SEND_PAUSE_OUT    <= send_pause;
      PAUSE_TIME_OUT    <= PAUSE_ADVERTISE;
    end
  end

endmodule // mac_pace_top

// ---- verif/mac_pace_monitor.sv ----
// Checker for register bus timing, hold-off and pause behaviour at the top ports.
// Assumes it is bound into mac_pace_top and sees only that module's ports.
`timescale 1ns/10ps
module mac_pace_monitor
  import mac_pace_pkg::*;
#(
  parameter int SLOT_CYC = SLOT_CYCLES,
  parameter int IPG_CYC  = IPG_CYCLES
) (
  input wire logic         MCLK_IN,
  input wire logic         SYS_RST_IN,
  input wire logic         PSEL_IN,
  input wire logic         PENABLE_IN,
  input wire logic [7:0]   PADDR_IN,
  input wire logic [31:0]  PRDATA_OUT,
  input wire logic         PREADY_OUT,
  input wire tx_outcome_t  TX_OUTCOME_IN,
  input wire logic         PAUSE_SENT_IN,
  input wire logic         RX_PAUSE_SEEN_IN,
  input wire logic [15:0]  RX_PAUSE_QUANTA_IN,
  input wire logic         TX_START_OK_OUT,
  input wire logic         SEND_PAUSE_OUT,
  input wire logic [15:0]  PAUSE_TIME_OUT
);
  // ***************************************************************
  // Properties, all on the MAC clock.
  // ***************************************************************
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  chk_ready_wait:
  assert property (PSEL_IN && !PENABLE_IN ##1 PSEL_IN && PENABLE_IN && !PREADY_OUT
    |=> PREADY_OUT) else $error("bus answer missing after one wait state");
  chk_ready_pulse:
  assert property (PREADY_OUT |=> !PREADY_OUT) else $error("bus answer held too long");
  chk_pace_rsvd:
  assert property (PREADY_OUT && PADDR_IN == OFS_PACE |-> PRDATA_OUT[31:5] == 27'h0000000)
    else $error("pacing upper bits not zero");
  chk_pause_rsvd:
  assert property (PREADY_OUT && (PADDR_IN == OFS_RX_PAUSE || PADDR_IN == OFS_TX_PAUSE)
    |-> PRDATA_OUT[31:16] == 16'h0000) else $error("pause upper bits not zero");
  chk_pause_time:
  assert property (PAUSE_TIME_OUT == PAUSE_ADVERTISE) else $error("advertised pause wrong");
  chk_gap_hold:
  assert property (TX_OUTCOME_IN.done |-> ##2 !TX_START_OK_OUT [*4])
    else $error("new frame allowed inside the gap");
  chk_pause_hold:
  assert property (RX_PAUSE_SEEN_IN && RX_PAUSE_QUANTA_IN != 16'h0000 |-> ##2 !TX_START_OK_OUT)
    else $error("transmit not held after incoming pause");
  chk_sent_clear:
  assert property ($rose(PAUSE_SENT_IN) |-> ##2 !SEND_PAUSE_OUT [*4])
    else $error("pause request kept after it was sent");
  chk_reset_state:
  assert property ($fell(SYS_RST_IN) |-> TX_START_OK_OUT && !SEND_PAUSE_OUT)
    else $error("hold-off or request present after reset");
endmodule // mac_pace_monitor

// ---- verif/phy_link_model.sv ----
// Medium side model: sends frames when allowed and answers pause requests.
// Assumes the bench holds the collision and deferral flags until the frame ends.
`timescale 1ns/10ps
module phy_link_model
  import mac_pace_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  input  wire logic  start_ok_in,
  input  wire logic  send_pause_in,
  input  wire logic  slow_in,
  input  wire logic  go_in,
  input  wire logic  col_in,
  input  wire logic  dfr_in,
  output tx_outcome_t outcome_out,
  output logic       pause_sent_out
);
  logic       pend;     // A frame is queued for the medium.
  logic [2:0] wait_cnt; // Pause reply delay; threshold 3, or 7 with slow_in high, outlasts the request's fall.
  // Frames start only while allowed, and a pause reply follows each request once.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend           <= 1'b0;
      wait_cnt       <= 3'h0;
      outcome_out    <= '0;
      pause_sent_out <= 1'b0;
    end else begin
      outcome_out    <= '0;
      pause_sent_out <= 1'b0;
      if (go_in) begin
        pend <= 1'b1;
      end else if (pend && start_ok_in) begin
        pend        <= 1'b0;
        outcome_out <= {1'b1, col_in, dfr_in};
      end
      if (!send_pause_in) begin
        wait_cnt <= 3'h0;
      end else if (wait_cnt == (slow_in ? 3'h7 : 3'h3)) begin
        wait_cnt       <= 3'h0;
        pause_sent_out <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 3'h1;
      end
    end
  end
endmodule // phy_link_model

// ---- verif/mac_pace_top_tb.sv ----
// Self-checking bench: register bus, pacing gaps, pause timers and address filter.
// Assumes short slot and gap parameters so the whole run stays brief.
`timescale 1ns/10ps
module mac_pace_top_tb
  import mac_pace_pkg::*;
;
  localparam int          SLOT = 8;
  localparam int          IPG  = 4;
  localparam logic [31:0] FULL = 32'hFFFFFFFF;
  logic        mclk, rst, psel, pen, pwr, psent, seen, cong, start_ok, send_pause;
  logic        pready, pslverr, da_v, go, col, dfr, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, last_rd, r;
  logic [15:0] quanta, ptime, da;
  tx_outcome_t outcome;
  filter_hit_t hit;
  logic [64:0] note_q[$];  // Expected {error, mask, data} of each bus access.
  logic [64:0] note;
  logic [7:0]  ofs[4] = '{OFS_PACE, OFS_RX_PAUSE, OFS_TX_PAUSE, OFS_FILTER};
  int          n_mismatch, comparisons, cyc, n, q;
  mac_pace_top #(.SLOT_CYC(SLOT), .IPG_CYC(IPG)) u_mac_pace_top (
    .MCLK_IN(mclk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .TX_OUTCOME_IN(outcome), .PAUSE_SENT_IN(psent),
    .RX_PAUSE_SEEN_IN(seen), .RX_PAUSE_QUANTA_IN(quanta), .RX_CONGESTED_IN(cong),
    .TX_START_OK_OUT(start_ok), .SEND_PAUSE_OUT(send_pause), .PAUSE_TIME_OUT(ptime),
    .RX_DA_LOW_IN(da), .RX_DA_VALID_IN(da_v), .RX_FILTER_HIT_OUT(hit));
  phy_link_model u_phy_link_model (.clk_in(mclk), .rst_in(rst), .start_ok_in(start_ok),
    .send_pause_in(send_pause), .slow_in(slow), .go_in(go), .col_in(col), .dfr_in(dfr),
    .outcome_out(outcome), .pause_sent_out(psent));
  always #4 mclk = ~mclk;
  // Compares one value with its expectation and counts the outcome.
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer; the watcher below judges its answer against the note.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic er);
    int k;
    note_q.push_back({er, m, e});
    @(posedge mclk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    k = 0;
    // Ready is looked at between edges so the edge that launches it is no race.
    do begin @(negedge mclk); k++; end while (pready !== 1'b1 && k < 50);
    @(posedge mclk);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  // The answer stands one cycle, so it is judged at the falling edge of that cycle.
  always @(negedge mclk) begin
    if (pready === 1'b1) begin
      note    = note_q.pop_front();
      last_rd = prdata;
      check({pslverr, prdata & note[63:32]}, {note[64], note[31:0]});
    end
  end
  // Counts cycles until a new frame is allowed, waiting at least three cycles.
  task automatic wait_ok(output int k);
    k = 0;
    do begin @(negedge mclk); k++; end while ((start_ok !== 1'b1 || k < 3) && k < 1000);
  endtask
  // Sends one frame and checks the gap that follows it.
  task automatic frame(input logic c, input logic f, input int gap);
    int k;
    @(posedge mclk);
    col <= c;
    dfr <= f;
    go  <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    k = 0;
    do begin @(negedge mclk); k++; end while (outcome.done !== 1'b1 && k < 100);
    wait_ok(k);
    check(k, gap + 2);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A hang ends the run as a mismatch.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    {mclk, psel, pen, pwr, psent, seen, cong, da_v, go, col, dfr, slow} = '0;
    {paddr, pwdata, quanta, da, n_mismatch, comparisons, cyc} = '0;
    rst = 1'b1;
    void'($urandom(72450));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    foreach (ofs[i]) apb(1'b0, ofs[i], 32'h0, 32'h0, FULL, 1'b0);
    r = $urandom;
    apb(1'b1, 8'h10, r, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h10, 32'h0, 32'h0, FULL, 1'b1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ofs[i], $urandom, 32'h0, 32'h0, 1'b0);
      apb(1'b0, ofs[i], 32'h0, 32'h0, FULL, 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      r[20:19] = i[1:0];
      apb(1'b1, OFS_FILTER, r, 32'h0, 32'h0, 1'b0);
      apb(1'b0, OFS_FILTER, 32'h0, r & 32'h001FFFFF, FULL, 1'b0);
      da   <= (i < 6) ? r[15:0] : ~r[15:0];
      da_v <= 1'b1;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check({hit.accept, hit.reject}, {r[20] & r[19], r[20] & !r[19]} & {2{i < 6}});
      if (r[20] && r[19] && i < 6) check(hit.channel, r[18:16]);
    end
    da_v <= 1'b0;
    frame(1'b1, 1'b0, IPG);
    apb(1'b0, OFS_PACE, 32'h0, 32'h1F, FULL, 1'b0);
    for (int i = 0; i < 31; i++) frame(1'b0, 1'b0, 4 * IPG);
    apb(1'b0, OFS_PACE, 32'h0, 32'h0, FULL, 1'b0);
    frame(1'b0, 1'b0, IPG);
    apb(1'b0, OFS_PACE, 32'h0, 32'h0, FULL, 1'b0);
    frame(1'b0, 1'b1, IPG);
    apb(1'b0, OFS_PACE, 32'h0, 32'h1F, FULL, 1'b0);
    q = 3 + $urandom_range(2);
    @(posedge mclk);
    seen   <= 1'b1;
    quanta <= q[15:0];
    @(posedge mclk);
    seen <= 1'b0;
    wait_ok(n);
    check(n >= (q - 1) * SLOT && n <= q * SLOT + 4, 1'b1);
    apb(1'b0, OFS_TX_PAUSE, 32'h0, 32'h0, FULL, 1'b0);
    cong <= 1'b1;
    n = 0;
    do begin @(negedge mclk); n++; end while (psent !== 1'b1 && n < 50);
    check(psent, 1'b1);
    repeat (4) @(posedge mclk);
    apb(1'b0, OFS_RX_PAUSE, 32'h0, 32'h0, 32'hFFFF0000, 1'b0);
    check(last_rd <= 32'hFF00 && last_rd >= 32'hFEFE, 1'b1);
    check(send_pause, 1'b0);
    r = last_rd;
    repeat (3 * SLOT) @(posedge mclk);
    apb(1'b0, OFS_RX_PAUSE, 32'h0, 32'h0, 32'hFFFF0000, 1'b0);
    check(r - last_rd >= 3 && r - last_rd <= 4, 1'b1);
    slow <= 1'b1;
    rst  <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, OFS_PACE, 32'h0, 32'h0, FULL, 1'b0);
    n = 0;
    do begin @(negedge mclk); n++; end while (psent !== 1'b1 && n < 50);
    check(psent, 1'b1);
    cong <= 1'b0;
    repeat (4) @(posedge mclk);
    end_sim();
  end
endmodule // mac_pace_top_tb
bind mac_pace_top mac_pace_monitor #(.SLOT_CYC(SLOT_CYC), .IPG_CYC(IPG_CYC)) u_mac_pace_monitor (
  .MCLK_IN, .SYS_RST_IN, .PSEL_IN, .PENABLE_IN, .PADDR_IN, .PRDATA_OUT, .PREADY_OUT,
  .TX_OUTCOME_IN, .PAUSE_SENT_IN, .RX_PAUSE_SEEN_IN, .RX_PAUSE_QUANTA_IN, .TX_START_OK_OUT,
  .SEND_PAUSE_OUT, .PAUSE_TIME_OUT);
